// file: test/cfb_fuse_bank_chk.sv
// cfb_fuse_bank_chk: port-level assertions for the configuration fuse bank.
// assumes it is bound to cfb_fuse_bank and sees only that module's ports.
`default_nettype none
module cfb_fuse_bank_chk (
  // clock, reset and table access
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [21:0] tbl_addr_in,
  input wire logic tbl_rd_in,
  input wire logic tbl_wr_start_in,
  input wire logic [7:0] tbl_rdata_out,
  input wire logic tbl_wr_busy_out,
  // core status
  input wire logic soft_watchdog_enable_in,
  input wire logic stack_fault_in,
  input wire logic selfwrite_req_in,
  // observed controls
  input wire logic ext_reset_out,
  input wire logic shared_input_pin_out,
  input wire logic selfwrite_blocked_out,
  input wire logic usb_regulator_enable_out,
  input wire logic [1:0] brownout_level_out,
  input wire logic powerup_delay_timer_enable_out,
  input wire logic [15:0] watchdog_postscale_ratio_out,
  input wire logic watchdog_enable_out,
  input wire logic [4:0] analog_pin_config_reg_out,
  input wire logic capcomp2_pin_route_out,
  input wire logic debugger_enable_out,
  input wire logic extended_isa_enable_out,
  input wire logic stack_fault_reset_out,
  input wire logic [3:0] block_code_protect_out,
  input wire logic eeprom_code_protect_out,
  input wire logic boot_code_protect_out,
  input wire logic [3:0] block_write_protect_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic mapped;
  assign mapped = (tbl_addr_in[21:4] == 18'h30000) && (tbl_addr_in[3:0] inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA});

  // two edges after release the decoded snapshot has landed
  chk_ctrl_held: assert property (!$past(rst_in) && !$past(rst_in, 2) |-> $stable({usb_regulator_enable_out,
      brownout_level_out, powerup_delay_timer_enable_out, watchdog_postscale_ratio_out, capcomp2_pin_route_out,
      debugger_enable_out, extended_isa_enable_out})) else $error("static control moved outside reset");
  chk_protect_held: assert property (!$past(rst_in) && !$past(rst_in, 2) |-> $stable({block_code_protect_out,
      eeprom_code_protect_out, boot_code_protect_out, block_write_protect_out}))
    else $error("protection output moved outside reset");
  chk_analog_mask: assert property (!$past(rst_in) |-> $stable(analog_pin_config_reg_out))
    else $error("analog mask changed outside reset");
  chk_ratio_pow: assert property ($onehot(watchdog_postscale_ratio_out))
    else $error("postscale ratio not a power of two");
  chk_wdog_soft: assert property (!$past(rst_in) && $past(soft_watchdog_enable_in) |-> watchdog_enable_out)
    else $error("watchdog off while software enable set");
  chk_stack_cause: assert property (!$past(rst_in) && stack_fault_reset_out |-> $past(stack_fault_in))
    else $error("stack reset without stack fault");
  chk_pin_role: assert property (!(ext_reset_out && shared_input_pin_out))
    else $error("pin is reset and plain input at once");
  chk_sw_cause: assert property (selfwrite_blocked_out |-> $past(selfwrite_req_in))
    else $error("self-write blocked without a query");
  chk_write_time: assert property (tbl_wr_start_in && !tbl_wr_busy_out && mapped |=>
      tbl_wr_busy_out [*8] ##92 tbl_wr_busy_out ##1 !tbl_wr_busy_out) else $error("write busy span wrong");
  chk_rdata_hold: assert property (!$past(tbl_rd_in) && !$past(rst_in) |-> $stable(tbl_rdata_out))
    else $error("read data changed without a read");
  chk_unmapped_rd: assert property (tbl_rd_in && !mapped |=> tbl_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: test/cfb_fuse_bank_tb.sv
// cfb_fuse_bank_tb: self-checking bench for the configuration fuse bank.
// assumes the design's default parameters: block 3 present, debug port present, block 0 write start 000800.
`default_nettype none
module cfb_fuse_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic nv_init_in = 1'b1;
  logic [21:0] tbl_addr_in = 22'h000000;
  logic [21:0] selfwrite_addr_in = 22'h000000;
  logic [7:0] tbl_wdata_in = 8'h00;
  logic tbl_rd_in = 1'b0, tbl_wr_start_in = 1'b0, soft_brownout_enable_in = 1'b0;
  logic soft_watchdog_enable_in = 1'b0, sleep_in = 1'b0, stack_fault_in = 1'b0;
  logic master_reset_input_in = 1'b1, selfwrite_req_in = 1'b0;
  logic [7:0] tbl_rdata_out;
  logic [15:0] watchdog_postscale_ratio_out;
  logic [4:0] analog_pin_config_reg_out;
  logic [3:0] block_code_protect_out, block_write_protect_out;
  logic [1:0] brownout_level_out;
  logic tbl_wr_busy_out, ext_reset_out, shared_input_pin_out, selfwrite_blocked_out;
  logic usb_regulator_enable_out, brownout_reset_enable_out, powerup_delay_timer_enable_out;
  logic watchdog_enable_out, lowpower_sec_osc_enable_out, capcomp2_pin_route_out;
  logic debugger_enable_out, extended_isa_enable_out, dedicated_debug_port_enable_out;
  logic low_voltage_prog_enable_out, stack_fault_reset_out, eeprom_code_protect_out, boot_code_protect_out;
  int errors = 0;
  int samples_checked = 0;

  cfb_fuse_bank dut (.core_clk_in, .rst_in, .nv_init_in, .tbl_addr_in, .tbl_wdata_in, .tbl_rd_in,
    .tbl_wr_start_in, .tbl_rdata_out, .tbl_wr_busy_out, .soft_brownout_enable_in, .soft_watchdog_enable_in,
    .sleep_in, .stack_fault_in, .master_reset_input_in, .ext_reset_out, .shared_input_pin_out,
    .selfwrite_req_in, .selfwrite_addr_in, .selfwrite_blocked_out, .usb_regulator_enable_out,
    .brownout_reset_enable_out, .brownout_level_out, .powerup_delay_timer_enable_out,
    .watchdog_postscale_ratio_out, .watchdog_enable_out, .lowpower_sec_osc_enable_out,
    .analog_pin_config_reg_out, .capcomp2_pin_route_out, .debugger_enable_out, .extended_isa_enable_out,
    .dedicated_debug_port_enable_out, .low_voltage_prog_enable_out, .stack_fault_reset_out,
    .block_code_protect_out, .eeprom_code_protect_out, .boot_code_protect_out, .block_write_protect_out);

  always #5 core_clk_in = ~core_clk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // every task starts and ends just after a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  task automatic do_reset(input int n);
    rst_in = 1'b1;
    cyc(n);
    rst_in = 1'b0;
    cyc(1);
  endtask

  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    int k;
    tbl_addr_in = a;
    tbl_wdata_in = d;
    tbl_wr_start_in = 1'b1;
    cyc(1);
    tbl_wr_start_in = 1'b0;
    k = 0;
    while (tbl_wr_busy_out === 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk(k, 100);
  endtask

  task automatic rd(input logic [21:0] a, input logic [7:0] exp);
    tbl_addr_in = a;
    tbl_rd_in = 1'b1;
    cyc(1);
    tbl_rd_in = 1'b0;
    chk(tbl_rdata_out, exp);
  endtask

  task automatic sw(input logic [21:0] a, input logic exp);
    selfwrite_addr_in = a;
    selfwrite_req_in = 1'b1;
    cyc(1);
    selfwrite_req_in = 1'b0;
    chk(selfwrite_blocked_out, exp);
  endtask

  task automatic t_defaults;
    logic [7:0] dv[7] = '{8'h1F, 8'h1F, 8'h83, 8'h85, 8'h0F, 8'hC0, 8'h0F};
    logic [3:0] ao[7] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA};
    for (int i = 0; i < 7; i++) rd({18'h30000, ao[i]}, dv[i]);
    rd(22'h300004, 8'h00);
    chk(watchdog_enable_out, 1'b1);
    chk(lowpower_sec_osc_enable_out, 1'b0);
    chk(analog_pin_config_reg_out, 5'h1F);
    chk(capcomp2_pin_route_out, 1'b1);
    chk(debugger_enable_out, 1'b0);
    chk(low_voltage_prog_enable_out, 1'b1);
    chk({block_code_protect_out, block_write_protect_out}, 8'h00);
    chk({eeprom_code_protect_out, boot_code_protect_out}, 2'h0);
    stack_fault_in = 1'b1;
    master_reset_input_in = 1'b0;
    cyc(3);
    chk(stack_fault_reset_out, 1'b1);
    chk({ext_reset_out, shared_input_pin_out}, 2'h2);
    stack_fault_in = 1'b0;
    master_reset_input_in = 1'b1;
  endtask

  // two software/sleep settings, both high then both low, tell every brown-out mode apart
  task automatic t_power;
    logic [7:0] pb[4] = '{8'h2B, 8'h04, 8'h10, 8'h3E};
    logic [5:0] pe[4] = '{6'h32, 6'h1D, 6'h0C, 6'h27};
    logic prev = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(22'h300002, pb[i]);
      rd(22'h300002, pb[i]);
      chk(usb_regulator_enable_out, prev);
      do_reset(2);
      prev = pe[i][5];
      chk(usb_regulator_enable_out, pe[i][5]);
      chk(brownout_level_out, pe[i][4:3]);
      chk(powerup_delay_timer_enable_out, pe[i][2]);
      soft_brownout_enable_in = 1'b1;
      sleep_in = 1'b1;
      cyc(1);
      chk(brownout_reset_enable_out, pe[i][1]);
      soft_brownout_enable_in = 1'b0;
      sleep_in = 1'b0;
      cyc(1);
      chk(brownout_reset_enable_out, pe[i][0]);
    end
  endtask

  task automatic t_wdog;
    for (int i = 0; i < 16; i++) begin
      wr(22'h300003, {3'h0, 4'(i), 1'b0});
      soft_watchdog_enable_in = i[0];
      do_reset(2);
      chk(watchdog_postscale_ratio_out, 32'h1 << i);
      chk(watchdog_enable_out, i[0]);
    end
  endtask

  task automatic t_pins_debug;
    wr(22'h300005, 8'h04);
    wr(22'h300006, 8'hFF);
    rd(22'h300006, 8'hE5);
    wr(22'h300006, 8'h60);
    do_reset(2);
    chk({analog_pin_config_reg_out, capcomp2_pin_route_out}, 6'h00);
    chk(lowpower_sec_osc_enable_out, 1'b1);
    chk({debugger_enable_out, extended_isa_enable_out}, 2'h3);
    chk({dedicated_debug_port_enable_out, low_voltage_prog_enable_out}, 2'h2);
    master_reset_input_in = 1'b0;
    stack_fault_in = 1'b1;
    cyc(3);
    chk({ext_reset_out, shared_input_pin_out}, 2'h0);
    chk(stack_fault_reset_out, 1'b0);
    master_reset_input_in = 1'b1;
    stack_fault_in = 1'b0;
    cyc(3);
    chk({ext_reset_out, shared_input_pin_out}, 2'h1);
  endtask

  // block 3 bits stay set in every write below
  task automatic t_protect;
    wr(22'h300008, 8'h0A);
    wr(22'h300008, 8'h0F);
    rd(22'h300008, 8'h0A);
    wr(22'h300009, 8'h40);
    rd(22'h300009, 8'h40);
    wr(22'h30000A, 8'h0E);
    do_reset(2);
    chk(block_code_protect_out, 4'h5);
    chk({eeprom_code_protect_out, boot_code_protect_out}, 2'h2);
    chk(block_write_protect_out, 4'h1);
    sw(22'h000900, 1'b1);
    sw(22'h0007FF, 1'b0);
    sw(22'h002000, 1'b0);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    cyc(2);
    nv_init_in = 1'b0;
    do_reset(14);
    t_defaults;
    t_power;
    t_wdog;
    t_pins_debug;
    t_protect;
    end_sim;
  end

  // about 3000 cycles of traffic, so 10000 cycles leaves ample margin
  initial begin
    #100us;
    errors++;
    end_sim;
  end
endmodule

bind cfb_fuse_bank cfb_fuse_bank_chk u_chk (.core_clk_in, .rst_in, .tbl_addr_in, .tbl_rd_in, .tbl_wr_start_in,
  .tbl_rdata_out, .tbl_wr_busy_out, .soft_watchdog_enable_in, .stack_fault_in, .selfwrite_req_in, .ext_reset_out,
  .shared_input_pin_out, .selfwrite_blocked_out, .usb_regulator_enable_out, .brownout_level_out,
  .powerup_delay_timer_enable_out, .watchdog_postscale_ratio_out, .watchdog_enable_out,
  .analog_pin_config_reg_out, .capcomp2_pin_route_out, .debugger_enable_out, .extended_isa_enable_out,
  .stack_fault_reset_out, .block_code_protect_out, .eeprom_code_protect_out, .boot_code_protect_out,
  .block_write_protect_out);
`default_nettype wire

// file: verilog/cfb_fuse_bank.sv
// cfb_fuse_bank: configuration byte bank, table access and decoded controls.
// assumes table reads/writes come from core logic on core_clk_in; the reset pin is asynchronous.
//
// Contract
// - regulator enable bit drives usb regulator
// - mode 11 always, 10 off in sleep
// - mode 01 software controls, 00 off
// - threshold 11 lowest, 00 highest
// - power-up timer bit is active low
// - power-up timer independent of brown-out
// - postscale ratio is two to field
// - watchdog forced on, else software bit
// - reset pin or plain input pin
// - low-power secondary oscillator select
// - port b analog mask loaded each reset
// - capture/compare 2 routed port c or b
// - debug bit 0 enables debugger, dedicates pins
// - extended instruction set enable
// - dedicated debug port, largest package only
// - low-voltage programming entry gate
// - stack fault reset enable
// - four block code-protect bits, active low
// - eeprom and boot block code protect
// - block write protect blocks self-writes
// - protection bits clear-only
`default_nettype none
module cfb_fuse_bank #(
  parameter bit HAS_BLOCK3 = 1'b1,
  parameter bit HAS_DEBUG_PORT = 1'b1,
  parameter logic [21:0] BLOCK0_WR_START = cfb_pkg::BLOCK0_WR_START_DEFAULT
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // cell array initialisation (bulk erase to unprogrammed)
  input wire logic nv_init_in,
  // table access
  input wire logic [21:0] tbl_addr_in,
  input wire logic [7:0] tbl_wdata_in,
  input wire logic tbl_rd_in,
  input wire logic tbl_wr_start_in,
  output logic [7:0] tbl_rdata_out,
  output logic tbl_wr_busy_out,
  // software control bits and core status
  input wire logic soft_brownout_enable_in,
  input wire logic soft_watchdog_enable_in,
  input wire logic sleep_in,
  input wire logic stack_fault_in,
  // shared reset pin
  input wire logic master_reset_input_in,
  output logic ext_reset_out,
  output logic shared_input_pin_out,
  // self-write check
  input wire logic selfwrite_req_in,
  input wire logic [21:0] selfwrite_addr_in,
  output logic selfwrite_blocked_out,
  // decoded controls
  output logic usb_regulator_enable_out,
  output logic brownout_reset_enable_out,
  output logic [1:0] brownout_level_out,
  output logic powerup_delay_timer_enable_out,
  output logic [15:0] watchdog_postscale_ratio_out,
  output logic watchdog_enable_out,
  output logic lowpower_sec_osc_enable_out,
  output logic [4:0] analog_pin_config_reg_out,
  output logic capcomp2_pin_route_out,
  output logic debugger_enable_out,
  output logic extended_isa_enable_out,
  output logic dedicated_debug_port_enable_out,
  output logic low_voltage_prog_enable_out,
  output logic stack_fault_reset_out,
  output logic [3:0] block_code_protect_out,
  output logic eeprom_code_protect_out,
  output logic boot_code_protect_out,
  output logic [3:0] block_write_protect_out
);

  localparam logic [2:0] BAD_IDX = 3'h7;
  localparam logic [7:0] BLK3_BIT = 8'h08;
  localparam logic [$clog2(cfb_pkg::WRITE_CYCLES+1)-1:0] WR_LAST =
    ($clog2(cfb_pkg::WRITE_CYCLES+1))'(cfb_pkg::WRITE_CYCLES - 1);

  // table pointer to cell index; BAD_IDX for unmapped
  function automatic logic [2:0] cell_index(input logic [21:0] addr);
    case (addr)
      cfb_pkg::OFS_POWER_SUPERVISOR: cell_index = cfb_pkg::IDX_POWER;
      cfb_pkg::OFS_WATCHDOG: cell_index = cfb_pkg::IDX_WDOG;
      cfb_pkg::OFS_PIN_FUNCTION: cell_index = cfb_pkg::IDX_PINS;
      cfb_pkg::OFS_DEBUG_CORE: cell_index = cfb_pkg::IDX_DEBUG;
      cfb_pkg::OFS_BLOCK_READ_PROTECT: cell_index = cfb_pkg::IDX_CP;
      cfb_pkg::OFS_BOOT_EEPROM_PROTECT: cell_index = cfb_pkg::IDX_CPBE;
      cfb_pkg::OFS_BLOCK_WRITE_PROTECT: cell_index = cfb_pkg::IDX_WRT;
      default: cell_index = BAD_IDX;
    endcase
  endfunction

  // bits a part without block 3 holds at 1
  function automatic logic [7:0] forced_ones(input logic [2:0] idx);
    if (!HAS_BLOCK3 && (idx == cfb_pkg::IDX_CP || idx == cfb_pkg::IDX_WRT)) begin
      forced_ones = BLK3_BIT;
    end else begin
      forced_ones = 8'h00;
    end
  endfunction

  logic [7:0] cells [0:cfb_pkg::NUM_REGS-1];
  cfb_pkg::cfb_wr_state_e wr_state;
  logic [$clog2(cfb_pkg::WRITE_CYCLES+1)-1:0] wr_count;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;
  logic [2:0] rd_idx;
  logic [2:0] start_idx;
  logic [7:0] next_cell;
  cfb_pkg::cfb_ctrl_s ctrl;
  cfb_pkg::cfb_ctrl_s next_ctrl;
  logic pin_meta;
  logic pin_sync;

  assign rd_idx = cell_index(tbl_addr_in);
  assign start_idx = cell_index(tbl_addr_in);
  assign tbl_wr_busy_out = (wr_state == cfb_pkg::WR_BUSY);

  // self-timed byte write; new starts while busy are dropped
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_state <= cfb_pkg::WR_IDLE;
      wr_count <= '0;
      wr_idx <= BAD_IDX;
      wr_data <= 8'h00;
    end else begin
      case (wr_state)
        cfb_pkg::WR_IDLE: begin
          if (tbl_wr_start_in && start_idx != BAD_IDX) begin
            wr_state <= cfb_pkg::WR_BUSY;
            wr_idx <= start_idx;
            wr_data <= tbl_wdata_in;
            wr_count <= '0;
          end
        end
        cfb_pkg::WR_BUSY: begin
          if (wr_count == WR_LAST) begin
            wr_state <= cfb_pkg::WR_IDLE;
          end else begin
            wr_count <= wr_count + 1'b1;
          end
        end
        default: wr_state <= cfb_pkg::WR_IDLE;
      endcase
    end
  end

  // value a finishing write leaves in its cell
  always_comb begin
    next_cell = wr_data & cfb_pkg::CELL_MASK[wr_idx];
    // protection bits can only go from 1 to 0
    next_cell = (next_cell & ~cfb_pkg::CELL_CLEAR_ONLY[wr_idx])
      | (next_cell & cells[wr_idx] & cfb_pkg::CELL_CLEAR_ONLY[wr_idx]);
    next_cell = next_cell | forced_ones(wr_idx);
  end

  // nonvolatile cells: untouched by rst_in, so they survive system reset
  always_ff @(posedge core_clk_in) begin
    if (nv_init_in) begin
      for (int i = 0; i < cfb_pkg::NUM_REGS; i++) begin
        cells[i] <= cfb_pkg::CELL_DEFAULT[i];
      end
    end else if (!rst_in && wr_state == cfb_pkg::WR_BUSY && wr_count == WR_LAST) begin
      cells[wr_idx] <= next_cell;
    end
  end

  // table read: registered, implemented bits only, unmapped reads zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      tbl_rdata_out <= 8'h00;
    end else if (tbl_rd_in) begin
      if (rd_idx == BAD_IDX) begin
        tbl_rdata_out <= 8'h00;
      end else begin
        tbl_rdata_out <= (cells[rd_idx] & cfb_pkg::CELL_MASK[rd_idx]) | forced_ones(rd_idx);
      end
    end
  end

  // unpack cells into control fields
  always_comb begin
    next_ctrl.usb_regulator_enable = cells[cfb_pkg::IDX_POWER][cfb_pkg::POS_USB_REG];
    next_ctrl.brownout_threshold_sel = cells[cfb_pkg::IDX_POWER][cfb_pkg::POS_BOR_THRESH +: 2];
    next_ctrl.brownout_mode_sel = cells[cfb_pkg::IDX_POWER][cfb_pkg::POS_BOR_MODE +: 2];
    next_ctrl.powerup_delay_enable_n = cells[cfb_pkg::IDX_POWER][cfb_pkg::POS_PWRUP_N];
    next_ctrl.watchdog_postscale_sel = cells[cfb_pkg::IDX_WDOG][cfb_pkg::POS_WDOG_PS +: 4];
    next_ctrl.watchdog_force_enable = cells[cfb_pkg::IDX_WDOG][cfb_pkg::POS_WDOG_EN];
    next_ctrl.reset_pin_enable = cells[cfb_pkg::IDX_PINS][cfb_pkg::POS_RST_PIN];
    next_ctrl.lowpower_sec_osc_enable = cells[cfb_pkg::IDX_PINS][cfb_pkg::POS_LP_OSC];
    next_ctrl.portb_analog_at_reset = cells[cfb_pkg::IDX_PINS][cfb_pkg::POS_PORTB_AN];
    next_ctrl.capcomp2_pin_route = cells[cfb_pkg::IDX_PINS][cfb_pkg::POS_ROUTE];
    next_ctrl.debug_disable = cells[cfb_pkg::IDX_DEBUG][cfb_pkg::POS_DEBUG_N];
    next_ctrl.extended_isa_enable = cells[cfb_pkg::IDX_DEBUG][cfb_pkg::POS_EXT_ISA];
    // no such port outside the largest package
    next_ctrl.dedicated_debug_port_enable =
      HAS_DEBUG_PORT & cells[cfb_pkg::IDX_DEBUG][cfb_pkg::POS_DBG_PORT];
    next_ctrl.low_voltage_prog_enable = cells[cfb_pkg::IDX_DEBUG][cfb_pkg::POS_LVP];
    next_ctrl.stack_fault_reset_enable = cells[cfb_pkg::IDX_DEBUG][cfb_pkg::POS_STACK_RST];
    // block 3 bit reads as unprotected on parts without that block
    next_ctrl.block_code_protect_n = cells[cfb_pkg::IDX_CP][3:0] | {!HAS_BLOCK3, 3'h0};
    next_ctrl.eeprom_code_protect_n = cells[cfb_pkg::IDX_CPBE][cfb_pkg::POS_EEPROM_CP];
    next_ctrl.boot_code_protect_n = cells[cfb_pkg::IDX_CPBE][cfb_pkg::POS_BOOT_CP];
    next_ctrl.block_write_protect_n = cells[cfb_pkg::IDX_WRT][3:0] | {!HAS_BLOCK3, 3'h0};
  end

  // snapshot follows the cells only while reset is held
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl <= next_ctrl;
    end
  end

  // port b analog mask reloaded on every reset, software owns it after
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      analog_pin_config_reg_out <= {5{next_ctrl.portb_analog_at_reset}};
    end
  end

  // reset pin is asynchronous: two flops before use
  always_ff @(posedge core_clk_in) begin
    pin_meta <= master_reset_input_in;
    pin_sync <= pin_meta;
  end

  // pin role
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ext_reset_out <= 1'b0;
      shared_input_pin_out <= 1'b0;
    end else if (ctrl.reset_pin_enable) begin
      ext_reset_out <= ~pin_sync;
      shared_input_pin_out <= 1'b0;
    end else begin
      ext_reset_out <= 1'b0;
      shared_input_pin_out <= pin_sync;
    end
  end

  // brown-out and power-up timer decoded from separate fields
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      brownout_reset_enable_out <= 1'b0;
    end else begin
      case (ctrl.brownout_mode_sel)
        cfb_pkg::BOR_ALWAYS: brownout_reset_enable_out <= 1'b1;
        cfb_pkg::BOR_AWAKE: brownout_reset_enable_out <= ~sleep_in;
        cfb_pkg::BOR_SOFT: brownout_reset_enable_out <= soft_brownout_enable_in;
        cfb_pkg::BOR_OFF: brownout_reset_enable_out <= 1'b0;
        default: brownout_reset_enable_out <= 1'b0;
      endcase
    end
  end

  // watchdog: forced on by the fuse, otherwise the software bit
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      watchdog_enable_out <= 1'b0;
      stack_fault_reset_out <= 1'b0;
    end else begin
      watchdog_enable_out <= ctrl.watchdog_force_enable | soft_watchdog_enable_in;
      stack_fault_reset_out <= ctrl.stack_fault_reset_enable & stack_fault_in;
    end
  end

  // self-write check against block write protection only; the boot block below BLOCK0_WR_START is never blocked
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      selfwrite_blocked_out <= 1'b0;
    end else if (selfwrite_req_in) begin
      selfwrite_blocked_out <= 1'b0;
      for (int b = 0; b < 4; b++) begin
        if (!ctrl.block_write_protect_n[b]
            && selfwrite_addr_in >= ((b == 0) ? BLOCK0_WR_START : 22'(b) * cfb_pkg::BLOCK_SIZE)
            && selfwrite_addr_in < 22'(b + 1) * cfb_pkg::BLOCK_SIZE) begin
          selfwrite_blocked_out <= 1'b1;
        end
      end
    end else begin
      selfwrite_blocked_out <= 1'b0;
    end
  end

  // static controls straight from the snapshot
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      usb_regulator_enable_out <= 1'b0;
      brownout_level_out <= 2'h0;
      powerup_delay_timer_enable_out <= 1'b0;
      watchdog_postscale_ratio_out <= 16'h0001;
      lowpower_sec_osc_enable_out <= 1'b0;
      capcomp2_pin_route_out <= 1'b0;
      debugger_enable_out <= 1'b0;
      extended_isa_enable_out <= 1'b0;
      dedicated_debug_port_enable_out <= 1'b0;
      low_voltage_prog_enable_out <= 1'b0;
      block_code_protect_out <= 4'h0;
      eeprom_code_protect_out <= 1'b0;
      boot_code_protect_out <= 1'b0;
      block_write_protect_out <= 4'h0;
    end else begin
      usb_regulator_enable_out <= ctrl.usb_regulator_enable;
      // level 0 is the lowest trip point
      brownout_level_out <= ~ctrl.brownout_threshold_sel;
      powerup_delay_timer_enable_out <= ~ctrl.powerup_delay_enable_n;
      watchdog_postscale_ratio_out <= 16'h0001 << ctrl.watchdog_postscale_sel;
      lowpower_sec_osc_enable_out <= ctrl.lowpower_sec_osc_enable;
      capcomp2_pin_route_out <= ctrl.capcomp2_pin_route;
      debugger_enable_out <= ~ctrl.debug_disable;
      extended_isa_enable_out <= ctrl.extended_isa_enable;
      dedicated_debug_port_enable_out <= ctrl.dedicated_debug_port_enable;
      low_voltage_prog_enable_out <= ctrl.low_voltage_prog_enable;
      block_code_protect_out <= ~ctrl.block_code_protect_n;
      eeprom_code_protect_out <= ~ctrl.eeprom_code_protect_n;
      boot_code_protect_out <= ~ctrl.boot_code_protect_n;
      block_write_protect_out <= ~ctrl.block_write_protect_n;
    end
  end

endmodule
`default_nettype wire

// file: verilog/cfb_pkg.sv
// cfb_pkg: constants and types for the configuration fuse bank.
// assumes a 22-bit table pointer and byte-wide configuration cells.
`default_nettype none
package cfb_pkg;
  localparam int ADDR_W = 22;
  localparam int NUM_REGS = 7;

  // table addresses of the implemented configuration bytes
  localparam logic [21:0] OFS_POWER_SUPERVISOR = 22'h300002;
  localparam logic [21:0] OFS_WATCHDOG = 22'h300003;
  localparam logic [21:0] OFS_PIN_FUNCTION = 22'h300005;
  localparam logic [21:0] OFS_DEBUG_CORE = 22'h300006;
  localparam logic [21:0] OFS_BLOCK_READ_PROTECT = 22'h300008;
  localparam logic [21:0] OFS_BOOT_EEPROM_PROTECT = 22'h300009;
  localparam logic [21:0] OFS_BLOCK_WRITE_PROTECT = 22'h30000A;

  // cell indices inside the bank
  localparam logic [2:0] IDX_POWER = 3'h0;
  localparam logic [2:0] IDX_WDOG = 3'h1;
  localparam logic [2:0] IDX_PINS = 3'h2;
  localparam logic [2:0] IDX_DEBUG = 3'h3;
  localparam logic [2:0] IDX_CP = 3'h4;
  localparam logic [2:0] IDX_CPBE = 3'h5;
  localparam logic [2:0] IDX_WRT = 3'h6;

  // unprogrammed values, implemented-bit masks and clear-only masks, index 6 first
  localparam logic [6:0][7:0] CELL_DEFAULT = {8'h0F, 8'hC0, 8'h0F, 8'h85, 8'h83, 8'h1F, 8'h1F};
  localparam logic [6:0][7:0] CELL_MASK = {8'h0F, 8'hC0, 8'h0F, 8'hE5, 8'h87, 8'h1F, 8'h3F};
  localparam logic [6:0][7:0] CELL_CLEAR_ONLY = {8'h0F, 8'hC0, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};

  // field positions
  localparam int POS_PWRUP_N = 0;
  localparam int POS_BOR_MODE = 1;
  localparam int POS_BOR_THRESH = 3;
  localparam int POS_USB_REG = 5;
  localparam int POS_WDOG_EN = 0;
  localparam int POS_WDOG_PS = 1;
  localparam int POS_ROUTE = 0;
  localparam int POS_PORTB_AN = 1;
  localparam int POS_LP_OSC = 2;
  localparam int POS_RST_PIN = 7;
  localparam int POS_STACK_RST = 0;
  localparam int POS_LVP = 2;
  localparam int POS_DBG_PORT = 5;
  localparam int POS_EXT_ISA = 6;
  localparam int POS_DEBUG_N = 7;
  localparam int POS_BOOT_CP = 6;
  localparam int POS_EEPROM_CP = 7;

  // brown-out mode codes
  localparam logic [1:0] BOR_ALWAYS = 2'h3;
  localparam logic [1:0] BOR_AWAKE = 2'h2;
  localparam logic [1:0] BOR_SOFT = 2'h1;
  localparam logic [1:0] BOR_OFF = 2'h0;

  // program memory block boundaries
  localparam logic [21:0] BOOT_END = 22'h0007FF;
  localparam logic [21:0] BLOCK_SIZE = 22'h002000;
  localparam logic [21:0] BLOCK3_END = 22'h007FFF;
  localparam logic [21:0] BLOCK0_WR_START_DEFAULT = 22'h000800;

  // self-timed cell write
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_TIME_NS = 1000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_BUSY = 1'b1
  } cfb_wr_state_e;

  // decoded static controls, held from reset to reset
  typedef struct packed {
    logic usb_regulator_enable;
    logic [1:0] brownout_mode_sel;
    logic [1:0] brownout_threshold_sel;
    logic powerup_delay_enable_n;
    logic [3:0] watchdog_postscale_sel;
    logic watchdog_force_enable;
    logic reset_pin_enable;
    logic lowpower_sec_osc_enable;
    logic portb_analog_at_reset;
    logic capcomp2_pin_route;
    logic debug_disable;
    logic extended_isa_enable;
    logic dedicated_debug_port_enable;
    logic low_voltage_prog_enable;
    logic stack_fault_reset_enable;
    logic [3:0] block_code_protect_n;
    logic eeprom_code_protect_n;
    logic boot_code_protect_n;
    logic [3:0] block_write_protect_n;
  } cfb_ctrl_s;
endpackage
`default_nettype wire
